// File: sbf_params.svh
`ifndef SBF_PARAMS_SVH
`define SBF_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and filter times
// ----------------------------------------------------------------
`define SBF_CLK_MHZ       40
`define SBF_TDGC_ON_NS    10000
`define SBF_TDGC_OFF_NS   125000
`define SBF_TOL_ON_NS     20000
`define SBF_TMASK_NS      1000000
`define SBF_TSETTLE_MS    100
// Least time rounded up to whole clock cycles
`define SBF_CYC(ns)       ((((ns) * `SBF_CLK_MHZ) + 999) / 1000)

// ----------------------------------------------------------------
// Geometry and reset values
// ----------------------------------------------------------------
`define SBF_NHALF         4
`define SBF_NBRIDGE       2
`define SBF_POS_INIT      2'h0

`endif

// File: sbf_pkg.sv
package sbf_pkg;

   // ----------------------------------------------------------------
   // Fault codes
   // ----------------------------------------------------------------
   // Bridge fault register code
   typedef enum logic [2:0] {
      SBF_NONE    = 3'h0,
      SBF_OFF_OL  = 3'h1,
      SBF_OFF_SCG = 3'h2,
      SBF_OFF_SCB = 3'h3,
      SBF_OVC     = 3'h4,
      SBF_ON_OL   = 3'h5,
      SBF_RUNNING = 3'h6
   } sbf_code_e;

   // Single low-side channel code
   typedef enum logic [1:0] {
      SBF_CH_NONE = 2'h0,
      SBF_CH_OL   = 2'h1,
      SBF_CH_SCG  = 2'h2,
      SBF_CH_OVC  = 2'h3
   } sbf_ch_code_e;

   typedef logic [7:0] sbf_chcodes_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Control bits written by the host
   typedef struct packed {
      logic       cfg_single;
      logic       en;
      logic       dir;
      logic       step;
      logic [3:0] ch_cmd;
   } sbf_ctrl_s;

   // Analog comparator outputs, asynchronous to clk
   typedef struct packed {
      logic [3:0] ovc;
      logic [1:0] ol_on;
      logic [1:0] off_scg;
      logic [1:0] off_scb;
      logic [1:0] off_ol;
      logic [3:0] ch_ol;
      logic [3:0] ch_scg;
   } sbf_sense_s;

   // Switch commands, index 0..3 = OUTA..OUTD
   typedef struct packed {
      logic [3:0] hs;
      logic [3:0] ls;
   } sbf_gate_s;

endpackage

// File: sbf_sync.sv
`timescale 1ns/100ps

// Two-stage synchroniser for a vector of asynchronous levels
module sbf_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } sbf_sync_s;

   sbf_sync_s s;
   sbf_sync_s next_s;

   if (W < 1)
   begin : g_bad
      $error("sbf_sync: W must be at least 1");
   end

   // First stage is read only by the second stage
   always_comb
   begin
      next_s.meta = d;
      next_s.stab = s.meta;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign q = s.stab;
endmodule // sbf_sync

// File: sbf_filter.sv
`timescale 1ns/100ps

// Persistence filter: hit rises once cond held CYCLES clocks with en high
module sbf_filter #(
   parameter int CYCLES = 400
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic en,
   input  wire logic cond,
   output logic      hit
);
   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          hit;
   } sbf_filt_s;

   sbf_filt_s s;
   sbf_filt_s next_s;

   if (CYCLES < 1)
   begin : g_bad
      $error("sbf_filter: CYCLES must be at least 1");
   end

   // Restart on any gap so a glitch never accumulates
   always_comb
   begin
      next_s = s;
      if (!en || !cond)
         next_s.cnt = '0;                                  // R23
      else if (s.cnt != CW'(CYCLES))
         next_s.cnt = s.cnt + CW'(1);
      next_s.hit = (next_s.cnt == CW'(CYCLES));
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign hit = s.hit;
endmodule // sbf_filter

// File: sbf_top.sv
`timescale 1ns/100ps
`include "sbf_params.svh"

// Summary of operation
// (R1) Off bridges: filter short and open faults
// (R2) Mask off diagnosis after each on/off change
// (R3) Host waits settle time before disabling
// (R4) Persistent off fault is latched
// (R5) On-state fault overwrites latched off fault
// (R6) Latched off fault never blocks stepping
// (R7) Diagnosis read clears latched bridge faults
// (R8) Erroneous command off disables off diagnosis
// (R9) Filtered overcurrent switches bridge off, latches
// (R10) Bridge stays off until new step command
// (R11) Overcurrent reported above off-state faults
// (R12) Separate fault register per H-bridge
// (R13) Filtered low current flags on-state open load
// (R14) Report running first, classify on next step
// (R15) Running/open load drop if current returns
// (R16) Read clears running flag, detection resumes
// (R17) Single mode: two-bit code per channel
// (R18) Single mode: overcurrent on, open/short off
// (R19) Channel codes latched, cleared by read
// (R20) Off: first fault kept, on fault overwrites
// (R21) Step only on step bit rising, enabled
// (R22) Summary flag for fault on any output
// (R23) Filters restart when condition disappears
// (R24) Never both switches of a half on
module sbf_top #(
   parameter int TDGC_OFF_CYC = `SBF_CYC(`SBF_TDGC_OFF_NS),
   parameter int TMASK_CYC    = `SBF_CYC(`SBF_TMASK_NS)
) (
   input  wire logic           clk,
   input  wire logic           rst,
   input  sbf_pkg::sbf_ctrl_s  bridge_control_register,
   input  wire logic           pwm_pin,
   input  wire logic           cmd_error,
   input  wire logic           diag_read,
   input  sbf_pkg::sbf_sense_s sense,
   output sbf_pkg::sbf_gate_s  configurable_power_stages,
   output sbf_pkg::sbf_code_e  bridge1_fault_register,
   output sbf_pkg::sbf_code_e  bridge2_fault_register,
   output sbf_pkg::sbf_chcodes_t channel_fault_codes,
   output logic                any_output_fault_flag
);
   import sbf_pkg::*;

   // ----------------------------------------------------------------
   // Constants and state
   // ----------------------------------------------------------------
   localparam int TDGC_ON_CYC = `SBF_CYC(`SBF_TDGC_ON_NS);
   localparam int TOL_ON_CYC  = `SBF_CYC(`SBF_TOL_ON_NS);
   localparam int SW          = $bits(sbf_sense_s) + 1;

   typedef struct packed {
      logic [1:0]       pos;
      logic [1:0]       drive;
      logic [1:0]       on_q;
      logic             step_q;
      logic             bad_off;
      logic [1:0][2:0]  code;
      logic [1:0][2:0]  prov;
      logic [1:0][2:0]  rep;
      logic [3:0][1:0]  ch;
      logic             flag;
      sbf_gate_s        gate;
   } sbf_state_s;

   sbf_state_s s;
   sbf_state_s next_s;

   if (TDGC_OFF_CYC < 1 || TMASK_CYC < 1)
   begin : g_bad
      $error("sbf_top: filter counts must be at least 1");
   end

   // Half-bridge commands for one bridge: {hs[1:0], ls[1:0]}
   // Diagonal pairs only, so one half never gets both switches
   function automatic logic [3:0] bridge_gates(input logic flip);
      bridge_gates = flip ? 4'h9 : 4'h6;
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic [SW-1:0] sync_q;
   sbf_sense_s    sn;
   logic          pwm_s;

   sbf_sync #(
      .W (SW)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({sense, pwm_pin}),
      .q   (sync_q)
   );

   assign sn    = sbf_sense_s'(sync_q[SW-1:1]);
   assign pwm_s = sync_q[0];

   // ----------------------------------------------------------------
   // Operating conditions
   // ----------------------------------------------------------------
   sbf_ctrl_s  ctl;
   logic       single;
   logic       stp;
   logic       step_edge;
   logic [1:0] br_on;
   logic [1:0] chg;
   logic [1:0] off_ok;
   logic [1:0] mask_hit;
   logic [3:0] half_on;

   assign ctl    = bridge_control_register;
   assign single = ctl.cfg_single;
   // Effective step is the AND of the host bit and the pin
   // The edge is tracked while disabled, so setting en never steps alone
   assign stp       = ctl.step & pwm_s;
   assign step_edge = stp & ~s.step_q & ctl.en & ~single;       // R21
   assign br_on     = {2{~single & ctl.en}} & s.drive;
   assign chg       = br_on ^ s.on_q;
   // Off diagnosis only after the mask, never between a bad command and the next step
   assign off_ok    = {2{~single & ~s.bad_off}} & ~br_on & mask_hit; // R8
   assign half_on   = s.gate.hs | s.gate.ls;

   // ----------------------------------------------------------------
   // Filters
   // ----------------------------------------------------------------
   logic [3:0] ovc_hit;
   logic [3:0] ch_ol_hit;
   logic [3:0] ch_scg_hit;
   logic [1:0] ol_on_hit;
   logic [1:0] scg_hit;
   logic [1:0] scb_hit;
   logic [1:0] ol_off_hit;

   // Per half-bridge: overcurrent while on, channel faults while off
   for (genvar h = 0; h < `SBF_NHALF; h++)
   begin : g_half
      sbf_filter #(.CYCLES (TDGC_ON_CYC)) u_ovc (
         .clk  (clk),
         .rst  (rst),
         .en   (half_on[h]),
         .cond (sn.ovc[h]),
         .hit  (ovc_hit[h])                                 // R9
      );
      sbf_filter #(.CYCLES (TDGC_OFF_CYC)) u_ch_ol (
         .clk  (clk),
         .rst  (rst),
         .en   (single & ~ctl.ch_cmd[h]),
         .cond (sn.ch_ol[h]),
         .hit  (ch_ol_hit[h])                               // R18
      );
      sbf_filter #(.CYCLES (TDGC_OFF_CYC)) u_ch_scg (
         .clk  (clk),
         .rst  (rst),
         .en   (single & ~ctl.ch_cmd[h]),
         .cond (sn.ch_scg[h]),
         .hit  (ch_scg_hit[h])
      );
   end

   // Per bridge: mask after transitions, off and on diagnosis
   for (genvar b = 0; b < `SBF_NBRIDGE; b++)
   begin : g_br
      sbf_filter #(.CYCLES (TMASK_CYC)) u_mask (
         .clk  (clk),
         .rst  (rst),
         .en   (1'b1),
         .cond (~chg[b]),
         .hit  (mask_hit[b])                                // R2
      );
      sbf_filter #(.CYCLES (TOL_ON_CYC)) u_ol_on (
         .clk  (clk),
         .rst  (rst),
         .en   (br_on[b]),
         .cond (sn.ol_on[b]),
         .hit  (ol_on_hit[b])                               // R13
      );
      sbf_filter #(.CYCLES (TDGC_OFF_CYC)) u_scg (
         .clk  (clk),
         .rst  (rst),
         .en   (off_ok[b]),
         .cond (sn.off_scg[b]),
         .hit  (scg_hit[b])                                 // R1
      );
      sbf_filter #(.CYCLES (TDGC_OFF_CYC)) u_scb (
         .clk  (clk),
         .rst  (rst),
         .en   (off_ok[b]),
         .cond (sn.off_scb[b]),
         .hit  (scb_hit[b])
      );
      sbf_filter #(.CYCLES (TDGC_OFF_CYC)) u_ol_off (
         .clk  (clk),
         .rst  (rst),
         .en   (off_ok[b]),
         .cond (sn.off_ol[b]),
         .hit  (ol_off_hit[b])
      );
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Clears are applied first so that a detection in the read cycle wins
   always_comb
   begin
      logic [3:0] g;
      logic [3:0] dec1;
      logic [3:0] dec2;
      g      = '0;
      dec1   = '0;
      dec2   = '0;
      next_s = s;
      next_s.step_q = stp;
      next_s.on_q   = br_on;

      // Stepping: a latched fault does not gate the step
      if (step_edge)
      begin
         next_s.pos     = ctl.dir ? s.pos + 2'h1 : s.pos - 2'h1;   // R21
         next_s.drive   = 2'b11;                                  // R6 R10
         next_s.bad_off = 1'b0;
      end
      if (!ctl.en || single)
         next_s.drive = 2'b00;
      if (cmd_error)
      begin
         next_s.drive   = 2'b00;
         next_s.bad_off = 1'b1;                                   // R8
      end

      // Read clears all fault codes, filters keep running
      if (diag_read)
      begin
         next_s.code = '0;                                        // R7
         next_s.prov = '0;                                        // R16
         next_s.ch   = '0;                                        // R19
      end

      // Bridge diagnosis, one register each
      for (int b = 0; b < `SBF_NBRIDGE; b++)
      begin
         if (!single && br_on[b] && (ovc_hit[2*b] || ovc_hit[2*b+1]))
         begin
            next_s.drive[b] = 1'b0;                               // R9 R10
            next_s.code[b]  = SBF_OVC;                            // R5 R11 R12
            next_s.prov[b]  = SBF_NONE;
         end
         else if (next_s.code[b] == SBF_NONE && (scb_hit[b] || scg_hit[b] || ol_off_hit[b]))
         begin
            // Short to battery outranks short to ground, then open load
            if (scb_hit[b])                                       // R4
               next_s.code[b] = SBF_OFF_SCB;
            else if (scg_hit[b])
               next_s.code[b] = SBF_OFF_SCG;
            else
               next_s.code[b] = SBF_OFF_OL;
         end

         // Provisional on-state open load
         // A read while the filter still holds re-arms running at once;
         // the host keeps seeing it until the load current recovers
         if (br_on[b] && s.prov[b] != SBF_NONE && !sn.ol_on[b])
            next_s.prov[b] = SBF_NONE;                            // R15
         else if (step_edge && s.prov[b] == SBF_RUNNING)
            next_s.prov[b] = SBF_ON_OL;                           // R14
         else if (step_edge && s.prov[b] == SBF_ON_OL)
         begin
            next_s.prov[b] = SBF_NONE;
            if (next_s.code[b] != SBF_OVC)
               next_s.code[b] = SBF_ON_OL;                        // R5
         end
         else if (ol_on_hit[b] && next_s.prov[b] == SBF_NONE && next_s.code[b] != SBF_OVC)
            next_s.prov[b] = SBF_RUNNING;                         // R14

         // Overcurrent first, then provisional, then latched off fault
         if (next_s.code[b] == SBF_OVC || next_s.prov[b] == SBF_NONE)
            next_s.rep[b] = next_s.code[b];                       // R11
         else
            next_s.rep[b] = next_s.prov[b];
      end

      // Single low-side channels
      for (int c = 0; c < `SBF_NHALF; c++)
      begin
         if (single && ovc_hit[c])
            next_s.ch[c] = SBF_CH_OVC;                            // R18 R20
         else if (next_s.ch[c] == SBF_CH_NONE && ch_scg_hit[c])
            next_s.ch[c] = SBF_CH_SCG;                            // R17 R20
         else if (next_s.ch[c] == SBF_CH_NONE && ch_ol_hit[c])
            next_s.ch[c] = SBF_CH_OL;
      end

      // Switch commands; bridges decode the step position
      if (single)
      begin
         next_s.gate.hs = 4'h0;
         next_s.gate.ls = ctl.ch_cmd;
      end
      else
      begin
         if (ctl.en && next_s.drive[0])
            g[1:0] = 2'b11;
         if (ctl.en && next_s.drive[1])
            g[3:2] = 2'b11;
         dec1 = bridge_gates(next_s.pos[1]);
         dec2 = bridge_gates(~(next_s.pos[1] ^ next_s.pos[0]));
         next_s.gate.hs = {dec2[3:2], dec1[3:2]} & g;
         next_s.gate.ls = {dec2[1:0], dec1[1:0]} & g;
      end
      // Guard against shoot-through whatever the decode says
      next_s.gate.ls = next_s.gate.ls & ~next_s.gate.hs;          // R24

      next_s.flag = (next_s.rep[0] != SBF_NONE) || (next_s.rep[1] != SBF_NONE)
                    || (next_s.ch != '0);                         // R22
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s     <= '0;
         s.pos <= `SBF_POS_INIT;
      end
      else
         s <= next_s;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Straight from the state register, so no glitch reaches a pin
   assign configurable_power_stages = s.gate;
   assign bridge1_fault_register    = sbf_code_e'(s.rep[0]);
   assign bridge2_fault_register    = sbf_code_e'(s.rep[1]);
   assign channel_fault_codes       = s.ch;
   assign any_output_fault_flag     = s.flag;
endmodule // sbf_top

// File: sbf_load.sv
`timescale 1ns/100ps

// Behavioural motor and load as the comparators see it
module sbf_load
import sbf_pkg::*;
(
   input  sbf_pkg::sbf_gate_s  gates,
   input  wire logic [3:0]     short_half,
   input  wire logic           open_b1,
   input  wire logic [2:0]     off_inj,
   input  wire logic [3:0]     ch_open,
   output sbf_pkg::sbf_sense_s sense
);
   import sbf_pkg::*;

   logic b1_on;

   // ------------
   // Comparators
   // ------------
   // Off faults only show on an idle bridge, load current only on a driven one
   always_comb
   begin
      b1_on         = |{gates.hs[1:0], gates.ls[1:0]};
      sense         = '0;
      sense.ovc     = short_half & (gates.hs | gates.ls);
      sense.ol_on   = {1'b0, open_b1 & b1_on};
      sense.off_scb = {1'b0, off_inj[2] & ~b1_on};
      sense.off_scg = {1'b0, off_inj[1] & ~b1_on};
      sense.off_ol  = {1'b0, off_inj[0] & ~b1_on};
      sense.ch_ol   = ch_open & ~gates.ls;
   end
endmodule // sbf_load

// File: sbf_top_asserts.sv
`timescale 1ns/100ps

// Temporal checks on the bridge drive and bridge 1 fault code
module sbf_top_asserts
import sbf_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  sbf_pkg::sbf_ctrl_s bridge_control_register,
   input  wire logic          cmd_error,
   input  wire logic          diag_read,
   input  sbf_pkg::sbf_gate_s configurable_power_stages,
   input  sbf_pkg::sbf_code_e bridge1_fault_register
);
   import sbf_pkg::*;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic [3:0] b1g;

   // Bridge 1 switch bits
   assign b1g = {configurable_power_stages.hs[1:0], configurable_power_stages.ls[1:0]};

   // ------------
   // Properties
   // ------------
   // Two bridge-mode cycles with the step bit low
   sequence s_quiet;
      (!bridge_control_register.step && !bridge_control_register.cfg_single) [*2];
   endsequence

   a_no_shoot_through: assert property ((configurable_power_stages.hs & configurable_power_stages.ls) == 4'h0)
      else $error("high and low switch of one half on together");
   a_disable_clears: assert property (!bridge_control_register.en && !bridge_control_register.cfg_single
      |=> configurable_power_stages == 8'h00)
      else $error("bridge driven while disabled");
   a_quiet_holds: assert property (s_quiet
      |=> (configurable_power_stages & ~$past(configurable_power_stages)) == 8'h00)
      else $error("switch turned on without step edge");
   a_error_forces_off: assert property (cmd_error && !bridge_control_register.cfg_single
      |=> configurable_power_stages == 8'h00)
      else $error("bad command did not switch bridges off");
   a_ovc_shutdown: assert property ($changed(bridge1_fault_register) && bridge1_fault_register == SBF_OVC
      |-> b1g == 4'h0)
      else $error("overcurrent code without shutdown");
   a_ovc_stays_off: assert property (bridge1_fault_register == SBF_OVC && b1g == 4'h0
      && !bridge_control_register.step |=> b1g == 4'h0)
      else $error("bridge back on without step");
   // A provisional code that drops back may uncover an older off fault while driven
   a_off_when_idle: assert property ($changed(bridge1_fault_register)
      && !($past(bridge1_fault_register) inside {SBF_RUNNING, SBF_ON_OL})
      && bridge1_fault_register inside {SBF_OFF_OL, SBF_OFF_SCG, SBF_OFF_SCB} |-> $past(b1g) == 4'h0)
      else $error("off fault taken while bridge driven");
   a_running_first: assert property ($past(bridge1_fault_register) == SBF_NONE
      |-> bridge1_fault_register != SBF_ON_OL)
      else $error("open load reported without running code");
   a_off_latched: assert property (bridge1_fault_register inside {SBF_OFF_OL, SBF_OFF_SCG, SBF_OFF_SCB}
      && !diag_read |=> bridge1_fault_register != SBF_NONE)
      else $error("off fault lost without read");
endmodule // sbf_top_asserts

bind sbf_top sbf_top_asserts i_chk (
   .clk                       (clk),
   .rst                       (rst),
   .bridge_control_register   (bridge_control_register),
   .cmd_error                 (cmd_error),
   .diag_read                 (diag_read),
   .configurable_power_stages (configurable_power_stages),
   .bridge1_fault_register    (bridge1_fault_register)
);

// File: sbf_top_tb.sv
`timescale 1ns/100ps

// Directed bench for the stepper bridge fault block
module sbf_top_tb;
   import sbf_pkg::*;

   logic         clk, rst, pwm_pin, cmd_error, diag_read, open_b1, flag;
   logic [3:0]   short_half, ch_open, b1g;
   logic [2:0]   off_inj;
   sbf_ctrl_s    ctl;
   sbf_sense_s   sense;
   sbf_gate_s    gates;
   sbf_code_e    b1, b2;
   sbf_chcodes_t chc;
   int           n_mismatch, check_count;

   assign b1g = {gates.hs[1:0], gates.ls[1:0]};

   // Short filters keep the off-state scenarios brief
   sbf_top #(.TDGC_OFF_CYC(20), .TMASK_CYC(30)) i_dut (
      .clk(clk), .rst(rst), .bridge_control_register(ctl), .pwm_pin(pwm_pin),
      .cmd_error(cmd_error), .diag_read(diag_read), .sense(sense),
      .configurable_power_stages(gates), .bridge1_fault_register(b1),
      .bridge2_fault_register(b2), .channel_fault_codes(chc), .any_output_fault_flag(flag));

   sbf_load i_load (.gates(gates), .short_half(short_half), .open_b1(open_b1),
      .off_inj(off_inj), .ch_open(ch_open), .sense(sense));

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ------------
   // Tasks
   // ------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Look one step after the edge so its updates have landed
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      #1;
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Bounded wait on bridge 1 code or channel codes; a run-out ends the test
   task automatic wait_for(input bit ch, input logic [7:0] exp);
      int i;
      for (i = 0; i < 3000 && (ch ? chc : {5'h0, b1}) !== exp; i++)
         @(posedge clk);
      check(ch ? chc : {5'h0, b1}, exp);
      if ((ch ? chc : {5'h0, b1}) !== exp)
         results();
   endtask

   // Step bit low for one cycle then high
   task automatic step_once;
      ctl.step <= 1'b0;
      tick(1);
      ctl.step <= 1'b1;
      tick(2);
   endtask

   task automatic pulse_read;
      diag_read <= 1'b1;
      tick(1);
      diag_read <= 1'b0;
      tick(1);
   endtask

   // ------------
   // Sequence
   // ------------
   initial
   begin
      rst = 1'b1;
      ctl = '0;
      {pwm_pin, cmd_error, diag_read, open_b1} = 4'h0;
      {short_half, ch_open, off_inj} = '0;
      n_mismatch = 0;
      check_count = 0;
      tick(12);
      rst <= 1'b0;
      tick(2);
      check(gates, 8'h00);
      check(b1, 8'h00);
      ctl.en <= 1'b1;
      ctl.dir <= 1'b1;
      pwm_pin <= 1'b1;
      tick(4);
      step_once();
      check(gates, 8'h5a);
      ctl.step <= 1'b0;
      tick(3);
      check(gates, 8'h5a);
      step_once();
      check(gates, 8'h69);
      ctl.dir <= 1'b0;
      tick(1);
      step_once();
      check(gates, 8'h5a);
      // Settle wait after the last step, scaled down for simulation
      tick(8);
      ctl.en <= 1'b0;
      off_inj <= 3'h4;
      step_once();
      check(gates, 8'h00);
      tick(7);
      check(b1, 8'h00);
      wait_for(0, 8'h03);
      check(flag, 8'h01);
      off_inj <= 3'h1;
      tick(40);
      check(b1, 8'h03);
      off_inj <= 3'h0;
      tick(3);
      pulse_read();
      check(b1, 8'h00);
      check(flag, 8'h00);
      // Overcurrent on top of a latched off fault
      off_inj <= 3'h2;
      wait_for(0, 8'h02);
      ctl.en <= 1'b1;
      tick(1);
      step_once();
      check(|b1g, 8'h01);
      short_half <= 4'h3;
      wait_for(0, 8'h04);
      check(b1g, 8'h00);
      check({gates.hs[3:2], gates.ls[3:2]}, 8'h09);
      check(b2, 8'h00);
      short_half <= 4'h0;
      tick(60);
      check(b1, 8'h04);
      check(b1g, 8'h00);
      step_once();
      check(|b1g, 8'h01);
      off_inj <= 3'h0;
      tick(3);
      pulse_read();
      check(b1, 8'h00);
      // Bad command: off without off-state diagnosis
      off_inj <= 3'h4;
      cmd_error <= 1'b1;
      tick(1);
      cmd_error <= 1'b0;
      tick(2);
      check(gates, 8'h00);
      tick(80);
      check(b1, 8'h00);
      off_inj <= 3'h0;
      tick(3);
      // Open load while driven
      step_once();
      open_b1 <= 1'b1;
      wait_for(0, 8'h06);
      step_once();
      wait_for(0, 8'h05);
      open_b1 <= 1'b0;
      wait_for(0, 8'h00);
      // Single low-side channels
      ctl.en <= 1'b0;
      ctl.cfg_single <= 1'b1;
      ch_open <= 4'h2;
      wait_for(1, 8'h04);
      ch_open <= 4'h0;
      tick(3);
      pulse_read();
      wait_for(1, 8'h00);
      // Overcurrent on a driven channel, then an off fault must not replace it
      ctl.ch_cmd <= 4'h1;
      short_half <= 4'h1;
      wait_for(1, 8'h03);
      check(gates, 8'h01);
      short_half <= 4'h0;
      ctl.ch_cmd <= 4'h0;
      ch_open <= 4'h1;
      tick(40);
      check(chc, 8'h03);
      results();
   end
endmodule // sbf_top_tb
